// ===== sof_frame_tracker.sv
`timescale 1ns/1ps
module sof_frame_tracker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sof_token_rx,
    input wire logic [10:0] sof_frame_number,
    input wire logic artificial_sof,
    input wire logic frame_timer_locked,
    input wire logic feature_ctl_bit,
    input wire logic pending_write_guard,
    input wire logic irq_channel_en,
    output logic sof_irq_req,
    output logic frame_start_pin_n,
    output logic [sof_pkg::EP_SEL_MSB:0] endpoint_index
);
    import sof_pkg::*;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    localparam logic [11:0] EP_ADDR = {ENDPOINT_SELECT_IDX, 2'b00};
    localparam logic [11:0] LOW_ADDR = {FRAME_NUMBER_LOW_IDX, 2'b00};
    localparam logic [11:0] HIGH_ADDR = {FRAME_STATUS_HIGH_IDX, 2'b00};

    sof_state_t st;
    sof_state_t next_st;
    logic hit;
    logic sel_ep;
    logic sel_low;
    logic sel_high;
    logic [7:0] rd_value;
    logic wr_en;
    logic wr_ep;
    logic wr_low;
    logic wr_high;
    logic hw_frame;
    logic fw_set_flag;
    logic set_flag;
    logic [7:0] status_high;

    always_comb begin
        sel_ep = 1'b0;
        sel_low = 1'b0;
        sel_high = 1'b0;
        rd_value = 8'h00;
        if (paddr == EP_ADDR) begin
            sel_ep = 1'b1;
            rd_value = {5'b0_0000, st.ep_sel};
        end else if (paddr == LOW_ADDR) begin
            sel_low = 1'b1;
            rd_value = st.fn[7:0];
        end else if (paddr == HIGH_ADDR) begin
            sel_high = 1'b1;
            rd_value = status_high;
        end
        hit = sel_ep || sel_low || sel_high;
    end

    // lock bit is the live timer state
    // upper three frame bits in bits 2:0
    assign status_high = {st.token_valid, st.flag, st.irq_en, frame_timer_locked,
                          st.out_dis, st.fn[10:8]};

    apb_reg_port u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pstrb(pstrb),
        .hit(hit),
        .rd_value(rd_value),
        .wr_en(wr_en),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr)
    );

    assign wr_ep = wr_en && sel_ep;
    assign wr_low = wr_en && sel_low;
    assign wr_high = wr_en && sel_high;

    // ----------------------------------------
    // frame events
    // ----------------------------------------
    // real or artificial frame, lock state ignored
    assign hw_frame = sof_token_rx || artificial_sof;
    // firmware set is treated as a hardware set
    assign fw_set_flag = wr_high && pwdata[FLAG_BIT];
    assign set_flag = hw_frame || fw_set_flag;

    always_comb begin
        next_st = st;

        // error-free token marks the stored number valid
        if (sof_token_rx) begin
            next_st.token_valid = 1'b1;
        end else if (artificial_sof) begin
            next_st.token_valid = 1'b0;
        end

        // set wins over any clear in the same cycle
        if (set_flag) begin
            next_st.flag = 1'b1;
        // firmware clear path when self-clear is off
        end else if (wr_high) begin
            next_st.flag = 1'b0;
        end else if (!st.out_dis && !feature_ctl_bit) begin
            next_st.flag = 1'b0;
        end

        // guarded bits change only with the pending-write guard up
        // only firmware writes touch the enable
        if (wr_high && pending_write_guard) begin
            next_st.irq_en = pwdata[IRQ_EN_BIT];
            next_st.out_dis = pwdata[OUT_DIS_BIT];
        end

        // firmware may rewrite the stored number, e.g. after an artificial start
        if (wr_low) begin
            next_st.fn[7:0] = pwdata[7:0];
        end
        if (wr_high) begin
            next_st.fn[10:8] = pwdata[FN_HIGH_MSB:0];
        end
        // token loads all eleven bits at once and beats firmware
        // artificial start leaves the number alone
        if (sof_token_rx) begin
            next_st.fn = sof_frame_number;
        end

        // endpoint pair select; upper bits dropped
        if (wr_ep) begin
            next_st.ep_sel = pwdata[EP_SEL_MSB:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{token_valid: FRAME_STATUS_HIGH_RESET[TOKEN_VALID_BIT],
                    flag: FRAME_STATUS_HIGH_RESET[FLAG_BIT],
                    irq_en: FRAME_STATUS_HIGH_RESET[IRQ_EN_BIT],
                    out_dis: FRAME_STATUS_HIGH_RESET[OUT_DIS_BIT],
                    fn: {FRAME_STATUS_HIGH_RESET[FN_HIGH_MSB:0], FRAME_NUMBER_LOW_RESET},
                    ep_sel: ENDPOINT_SELECT_RESET[EP_SEL_MSB:0]};
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // request gated by enable and channel
    assign sof_irq_req = st.flag && st.irq_en && irq_channel_en;
    // index for the endpoint-indexed register bank
    assign endpoint_index = st.ep_sel;

    // pin pulse follows each flag set while the pin output is enabled, even self-clearing ones
    frame_pin_pulse u_pin (
        .pclk(pclk),
        .presetn(presetn),
        .start(set_flag),
        .pin_disable(st.out_dis),
        .frame_start_pin_n(frame_start_pin_n)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence token_seen;
        sof_token_rx;
    endsequence

    sequence fake_frame;
        artificial_sof && !sof_token_rx;
    endsequence

    sequence status_read;
        psel && !penable && !pwrite && paddr == HIGH_ADDR;
    endsequence

    a_token_sets_valid: assert property (token_seen |=> st.token_valid)
        else $error("token did not set valid bit");

    a_fake_clears_valid: assert property (fake_frame |=> !st.token_valid)
        else $error("artificial start left valid bit set");

    a_frame_sets_flag: assert property (hw_frame |=> st.flag && status_high[FLAG_BIT])
        else $error("new frame did not set flag");

    // a write that also disables the pin cuts the pulse to one clock, so it is left out here
    a_fw_flag_pulse: assert property (fw_set_flag && !st.out_dis &&
        !(pending_write_guard && pwdata[OUT_DIS_BIT]) |=> st.flag ##1 !frame_start_pin_n)
        else $error("firmware set did not act as hardware set");

    a_flag_self_clear: assert property (st.flag && !st.out_dis && !feature_ctl_bit && !set_flag
        |=> !st.flag)
        else $error("flag did not self-clear");

    a_flag_kept: assert property (st.flag && (st.out_dis || feature_ctl_bit) && !wr_high
        |=> st.flag)
        else $error("flag cleared without firmware");

    a_irq_cause: assert property (hw_frame && st.irq_en && !wr_high ##1 irq_channel_en |-> sof_irq_req)
        else $error("new frame gave no interrupt request");

    a_irq_en_hold: assert property (!(wr_high && pending_write_guard) |=> $stable(st.irq_en))
        else $error("interrupt enable changed without write");

    a_lock_readback: assert property (status_read |=> prdata[LOCK_BIT] == $past(frame_timer_locked))
        else $error("lock bit read wrong");

    a_pin_held_high: assert property (st.out_dis |=> frame_start_pin_n)
        else $error("pin driven low while disabled");

    a_frame_capture: assert property (token_seen |=> st.fn == $past(sof_frame_number))
        else $error("frame number not loaded whole");

    a_high_bits_read: assert property (status_read |=> prdata[FN_HIGH_MSB:0] == $past(st.fn[10:8]))
        else $error("frame high bits misplaced");

    a_fake_keeps_fn: assert property ((fake_frame and (!wr_low && !wr_high)) |=> $stable(st.fn))
        else $error("artificial start changed frame number");

    a_ep_index_load: assert property (wr_ep |=> endpoint_index == $past(pwdata[EP_SEL_MSB:0]))
        else $error("endpoint index not loaded");

    a_ep_reserved_zero: assert property (psel && !penable && paddr == EP_ADDR
        |=> prdata[31:3] == 29'h0000_0000)
        else $error("endpoint select reserved bits not zero");

    a_guard_blocks: assert property (wr_high && !pending_write_guard |=> $stable(st.out_dis))
        else $error("guarded bit written without guard");
endmodule

// ===== sof_pkg.sv
// Behaviour
// - set token-valid bit whenever an error-free SOF token arrives.
// - clear token-valid bit when the frame timer makes an artificial frame start.
// - set frame-start flag on every new frame, locked or not.
// - firmware writing 1 to frame-start flag acts exactly like a hardware set.
// - with both those bits 0, frame-start flag self-clears after one clock.
// - interrupt request only while flag, interrupt enable and channel enable all set.
// - hardware only reads the interrupt enable bit; firmware alone changes it.
// - lock bit reads 1 while frame timer locked, else 0.
// - pin output disabled holds frame-start pin high with no pulse.
// - pin enabled: each flag set drives frame-start pin low eight clocks.
// - upper three frame bits in high bits 2:0, lower eight in low register.
// - artificial frame start leaves the stored frame number unchanged.
// - endpoint select field bits 2:0 picks endpoint pair 0 to 7.
// - endpoint select bits 7:3 read zero; firmware writes zero.
package sof_pkg;

    // ----------------------------------------
    // register indices, byte address is four times the index
    // ----------------------------------------
    localparam logic [9:0] ENDPOINT_SELECT_IDX = 10'h00a;
    localparam logic [9:0] FRAME_NUMBER_LOW_IDX = 10'h00e;
    localparam logic [9:0] FRAME_STATUS_HIGH_IDX = 10'h00f;

    localparam logic [7:0] ENDPOINT_SELECT_RESET = 8'h00;
    localparam logic [7:0] FRAME_NUMBER_LOW_RESET = 8'h00;
    localparam logic [7:0] FRAME_STATUS_HIGH_RESET = 8'h00;

    // ----------------------------------------
    // field positions in the status high and endpoint select registers
    // ----------------------------------------
    localparam int TOKEN_VALID_BIT = 7;
    localparam int FLAG_BIT = 6;
    localparam int IRQ_EN_BIT = 5;
    localparam int LOCK_BIT = 4;
    localparam int OUT_DIS_BIT = 3;
    localparam int FN_HIGH_MSB = 2;
    localparam int EP_SEL_MSB = 2;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PIN_PULSE_NS = 80;
    localparam logic [3:0] PIN_PULSE_CYCLES = 4'(PIN_PULSE_NS / CLK_PERIOD_NS);

    typedef struct packed {
        logic token_valid;
        logic flag;
        logic irq_en;
        logic out_dis;
        logic [10:0] fn;
        logic [2:0] ep_sel;
    } sof_state_t;

    typedef struct packed {
        logic [3:0] cnt;
        logic pin_n;
    } pin_state_t;

    typedef struct packed {
        logic [31:0] rdata;
    } apb_state_t;

endpackage

// ===== frame_pin_pulse.sv
`timescale 1ns/1ps
module frame_pin_pulse (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic pin_disable,
    output logic frame_start_pin_n
);
    import sof_pkg::*;

    pin_state_t st;
    pin_state_t next_st;

    always_comb begin
        next_st = st;
        if (pin_disable) begin
            next_st.cnt = 4'h0;
        // retrigger restarts the eight cycle low pulse
        end else if (start) begin
            next_st.cnt = PIN_PULSE_CYCLES;
        end else if (st.cnt != 4'h0) begin
            next_st.cnt = st.cnt - 4'h1;
        end
        next_st.pin_n = (next_st.cnt == 4'h0);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{cnt: 4'h0, pin_n: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign frame_start_pin_n = st.pin_n;

    a_pulse_low_run: assert property (@(posedge pclk) disable iff (!presetn)
        start && !pin_disable ##1 (!pin_disable) [*7] |-> !frame_start_pin_n)
        else $error("frame pin pulse ended early");

    a_pulse_release: assert property (@(posedge pclk) disable iff (!presetn)
        start && !pin_disable ##1 (!start) [*8] |=> frame_start_pin_n)
        else $error("frame pin pulse too long");
endmodule

// ===== apb_reg_port.sv
`timescale 1ns/1ps
module apb_reg_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [3:0] pstrb,
    input wire logic hit,
    input wire logic [7:0] rd_value,
    output logic wr_en,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import sof_pkg::*;

    apb_state_t st;
    apb_state_t next_st;

    // read data captured in setup so it comes from a flop with no wait state
    always_comb begin
        next_st = st;
        if (psel && !penable) begin
            next_st.rdata = (hit && !pwrite) ? {24'h00_0000, rd_value} : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{rdata: 32'h0000_0000};
        end else begin
            st <= next_st;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign wr_en = psel && penable && pwrite && pstrb[0] && hit;
    assign prdata = st.rdata;
endmodule

// ===== sof_host_model.sv
`timescale 1ns/1ps
module sof_host_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tok_req,
    input wire logic art_req,
    input wire logic lock_req,
    input wire logic [10:0] num_in,
    output logic sof_token_rx,
    output logic [10:0] sof_frame_number,
    output logic artificial_sof,
    output logic frame_timer_locked
);
    // ----------------------------------------
    // frame source
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sof_token_rx <= 1'b0;
            artificial_sof <= 1'b0;
            frame_timer_locked <= 1'b0;
            sof_frame_number <= 11'h2aa;
        end else begin
            sof_token_rx <= tok_req;
            artificial_sof <= art_req;
            frame_timer_locked <= lock_req;
            // number only valid with the pulse, scrambled otherwise
            sof_frame_number <= tok_req ? num_in : ~sof_frame_number;
        end
    end
endmodule

// ===== sof_frame_tracker_and_ep_index_test.sv
`timescale 1ns/1ps
module sof_frame_tracker_and_ep_index_test;
    import sof_pkg::*;
    localparam logic [11:0] EP = {ENDPOINT_SELECT_IDX, 2'b00};
    localparam logic [11:0] LO = {FRAME_NUMBER_LOW_IDX, 2'b00};
    localparam logic [11:0] HI = {FRAME_STATUS_HIGH_IDX, 2'b00};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic [3:0] pstrb = 0;
    logic pready, pslverr, e, tok_req = 0, art_req = 0, lock_req = 0;
    logic [10:0] num_in = 0, sof_frame_number, n;
    logic sof_token_rx, artificial_sof, frame_timer_locked;
    logic feature_ctl_bit = 0, pending_write_guard = 0, irq_channel_en = 0;
    logic sof_irq_req, frame_start_pin_n, irq_seen = 0;
    logic [2:0] endpoint_index;
    logic [31:0] seed = 32'hab23_f568;
    int n_mismatch = 0, num_checks = 0, lowcnt = 0, last_low = 0;

    always #5 pclk = ~pclk;

    sof_host_model host (.pclk(pclk), .presetn(presetn), .tok_req(tok_req),
        .art_req(art_req), .lock_req(lock_req), .num_in(num_in),
        .sof_token_rx(sof_token_rx), .sof_frame_number(sof_frame_number),
        .artificial_sof(artificial_sof), .frame_timer_locked(frame_timer_locked));

    sof_frame_tracker dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sof_token_rx(sof_token_rx), .sof_frame_number(sof_frame_number),
        .artificial_sof(artificial_sof), .frame_timer_locked(frame_timer_locked),
        .feature_ctl_bit(feature_ctl_bit), .pending_write_guard(pending_write_guard),
        .irq_channel_en(irq_channel_en), .sof_irq_req(sof_irq_req),
        .frame_start_pin_n(frame_start_pin_n), .endpoint_index(endpoint_index));

    // ----------------------------------------
    // monitors and helpers
    // ----------------------------------------
    always @(posedge pclk) begin
        if (sof_irq_req === 1'b1) irq_seen = 1;
        if (frame_start_pin_n === 1'b0) lowcnt++;
        else begin
            if (lowcnt != 0) last_low = lowcnt;
            lowcnt = 0;
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] st(input logic v, f, ie, l, od, input logic [2:0] h);
        return {24'h0, v, f, ie, l, od, h};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       input logic [3:0] s);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d}; pstrb <= s;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic ev(input logic t, input logic [10:0] v);
        @(posedge pclk);
        tok_req <= t; art_req <= ~t; num_in <= v;
        @(posedge pclk);
        tok_req <= 0; art_req <= 0;
        repeat (12) @(posedge pclk);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge pclk);
        n_mismatch++;
        wrap_up;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        apb(0, HI, 0, 4'hf); chk(r, st(0, 0, 0, 0, 0, 0));
        apb(0, LO, 0, 4'hf); chk(r, 32'h0);
        lock_req <= 1;
        apb(0, HI, 0, 4'hf); chk(r, st(0, 0, 0, 1, 0, 0));
        for (int i = 0; i < 8; i++) begin
            apb(1, EP, 8'(i), 4'hf);
            apb(0, EP, 0, 4'hf); chk(r, i);
            chk(endpoint_index, i);
        end
        apb(1, EP, 8'h05, 4'h0); chk(endpoint_index, 7);
        apb(0, 12'h100, 0, 4'hf); chk(r, 32'h0000_0000);
        chk(e, 1'b1);
        // guarded bit writes without the guard are dropped
        apb(1, HI, 8'h28, 4'hf);
        apb(0, HI, 0, 4'hf); chk(r, st(0, 0, 0, 1, 0, 0));
        pending_write_guard <= 1;
        irq_channel_en <= 1;
        apb(1, HI, 8'h20, 4'hf);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            n = (k == 0) ? 11'h7ff : seed[10:0];
            irq_seen = 0;
            ev(1, n);
            chk(last_low, 8);
            chk(irq_seen, 1);
            apb(0, LO, 0, 4'hf); chk(r, n[7:0]);
            apb(0, HI, 0, 4'hf); chk(r, st(1, 0, 1, 1, 0, n[10:8]));
        end
        last_low = 0;
        ev(0, 11'h123);
        chk(last_low, 8);
        apb(0, HI, 0, 4'hf); chk(r, st(0, 0, 1, 1, 0, n[10:8]));
        apb(0, LO, 0, 4'hf); chk(r, n[7:0]);
        feature_ctl_bit <= 1;
        irq_channel_en <= 0;
        irq_seen = 0;
        ev(1, n);
        chk(irq_seen, 0);
        apb(0, HI, 0, 4'hf); chk(r, st(1, 1, 1, 1, 0, n[10:8]));
        irq_channel_en <= 1;
        repeat (2) @(posedge pclk);
        chk(sof_irq_req, 1);
        apb(1, HI, {5'h04, n[10:8]}, 4'hf);
        apb(0, HI, 0, 4'hf); chk(r, st(1, 0, 1, 1, 0, n[10:8]));
        chk(sof_irq_req, 0);
        feature_ctl_bit <= 0;
        last_low = 0;
        apb(1, HI, {5'h0c, n[10:8]}, 4'hf);
        repeat (12) @(posedge pclk);
        chk(last_low, 8);
        apb(1, HI, {5'h05, n[10:8]}, 4'hf);
        last_low = 0;
        ev(1, n);
        chk(last_low, 32'h0000_0000);
        chk(lowcnt, 32'h0000_0000);
        chk(frame_start_pin_n, 1'b1);
        apb(0, HI, 0, 4'hf); chk(r, st(1, 1, 1, 1, 1, n[10:8]));
        wrap_up;
    end
endmodule
